/* File: design/dspc_pkg.sv */
// dspc_pkg: register map, field layout, reset values and enumerations
// of the sawtooth / tuning word / phase offset configuration block.
// assumes a 7-bit register address and 16-bit register data.

package dspc_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W  = 7;
  localparam int DATA_W  = 16;
  localparam int SAMP_W  = 12;
  localparam int TW_W    = 24;
  localparam int PHASE_W = 16;
  localparam int HOLD_W  = 6;
  localparam int NCH     = 4;
  localparam int SHIFT_W = 5;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_SAW_CH3_CH4 = 7'h36;
  localparam logic [ADDR_W-1:0] ADDR_SAW_CH1_CH2 = 7'h37;
  localparam logic [ADDR_W-1:0] ADDR_TW_HIGH     = 7'h3e;
  localparam logic [ADDR_W-1:0] ADDR_TW_LOW      = 7'h3f;
  localparam logic [ADDR_W-1:0] ADDR_PH_CH4      = 7'h40;
  localparam logic [ADDR_W-1:0] ADDR_PH_CH3      = 7'h41;
  localparam logic [ADDR_W-1:0] ADDR_PH_CH2      = 7'h42;
  localparam logic [ADDR_W-1:0] ADDR_PH_CH1      = 7'h43;
  localparam logic [ADDR_W-1:0] ADDR_TRIG_CTRL   = 7'h44;
  localparam logic [ADDR_W-1:0] ADDR_SRC_CTRL    = 7'h45;

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] SAW_CFG_RST = 16'h0404;
  localparam logic [DATA_W-1:0] REG_RST     = 16'h0000;

  // ==========================================================
  // field positions
  localparam int HOLD_ODD_LSB   = 10;
  localparam int SHAPE_ODD_LSB  = 8;
  localparam int HOLD_EVEN_LSB  = 2;
  localparam int SHAPE_EVEN_LSB = 0;
  localparam int TW_LOW_LSB     = 8;
  localparam int FIRST_ONLY_BIT = 1;
  localparam int COS_BIT_BASE   = 3;
  localparam int MSB_BIT_BASE   = 2;
  localparam int CH_BIT_STRIDE  = 4;
  localparam int PH_RAM_BIT     = 9;
  localparam int TW_RAM_BIT     = 0;
  localparam int RAM_PH_BITS    = 8;

  // ==========================================================
  // constants
  localparam logic [SAMP_W-1:0]  SAW_MAX      = 12'hfff;
  localparam logic [PHASE_W-1:0] COSINE_SHIFT = 16'h4000;
  localparam logic [TW_W-1:0]    TW_ONES      = 24'hffffff;

  typedef enum logic [1:0] {
    DSPC_RAMP_UP   = 2'h0,
    DSPC_RAMP_DOWN = 2'h1,
    DSPC_TRIANGLE  = 2'h2,
    DSPC_ZERO      = 2'h3
  } dspc_shape_t;

  typedef enum logic [1:0] {
    DSPC_FETCH_TW = 2'b01,
    DSPC_FETCH_PH = 2'b10
  } dspc_fetch_t;

endpackage

/* File: design/dspc_buf.sv */
// dspc_buf: two-entry buffer with valid/ready on both sides.
// assumes the filling side holds its data while in_ready_o is low.
`timescale 1ns/1ps

module dspc_buf #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  logic [W-1:0] hold_data;
  logic         hold_valid;
  logic         push;
  logic         pop;

  // full only when both entries are taken
  assign in_ready_o = !hold_valid;
  assign push       = in_valid_i && !hold_valid;
  assign pop        = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      out_valid_o <= 1'b0;
      hold_valid  <= 1'b0;
      out_data_o  <= '0;
      hold_data   <= '0;
    end else if (pop) begin
      if (hold_valid) begin
        out_data_o <= hold_data;
        hold_valid <= 1'b0;
      end else begin
        out_valid_o <= push;
        out_data_o  <= in_data_i;
      end
    end else if (push) begin
      if (out_valid_o) begin
        hold_data  <= in_data_i;
        hold_valid <= 1'b1;
      end else begin
        out_data_o  <= in_data_i;
        out_valid_o <= 1'b1;
      end
    end
  end

endmodule

/* File: design/dspc_top.sv */
// dspc_top: configuration registers, phase accumulator, per-channel
// phase offset and sawtooth generators of a four-channel generator.
// assumes a decoded host register port and a pattern RAM with one
// cycle of read latency after ram_addr_o.
`timescale 1ns/1ps

// Functional notes
// - six-bit hold count per channel, reset one
// - shape code picks up, down, triangle, zero
// - tuning word is upper sixteen plus eight
// - four sixteen-bit phase offsets, reset zero
// - delay once or every pattern, shared bit
// - per-channel cosine select, resets to sine
// - address steps on channel phase MSB when set
// - channel three phase from RAM top bits
// - tuning word from RAM at channel one
// - all control bits reset to zero
// - placement shifts RAM word inside word
// - begin addresses locate RAM-sourced words
module dspc_top
  import dspc_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          reg_wr_i,
  input  wire logic [dspc_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [dspc_pkg::DATA_W-1:0]   reg_wdata_i,
  output logic      [dspc_pkg::DATA_W-1:0]   reg_rdata_o,
  input  wire logic [dspc_pkg::SAMP_W-1:0]   pattern_begin_ch1_i,
  input  wire logic [dspc_pkg::SAMP_W-1:0]   pattern_begin_ch3_i,
  input  wire logic [dspc_pkg::SHIFT_W-1:0]  ram_freq_word_placement_i,
  output logic      [dspc_pkg::SAMP_W-1:0]   ram_addr_o,
  input  wire logic [dspc_pkg::SAMP_W-1:0]   ram_data_i,
  output logic                               first_pattern_only_delay_o,
  output logic      [dspc_pkg::NCH-1:0]      addr_step_o,
  output logic      [dspc_pkg::TW_W-1:0]     freq_word_o,
  output logic                               out_valid_o,
  input  wire logic                          out_ready_i,
  output logic      [dspc_pkg::NCH*dspc_pkg::SAMP_W-1:0]  ch_sample_o,
  output logic      [dspc_pkg::NCH*dspc_pkg::PHASE_W-1:0] ch_phase_o
);
  import dspc_pkg::*;

  // ==========================================================
  // registers
  logic [DATA_W-1:0] sawtooth_cfg_ch1_ch2;
  logic [DATA_W-1:0] sawtooth_cfg_ch3_ch4;
  logic [DATA_W-1:0] tuning_word_high;
  logic [DATA_W-1:0] tuning_word_low;
  logic [DATA_W-1:0] phase_offset [NCH];
  logic [DATA_W-1:0] pattern_trigger_ctrl;
  logic [DATA_W-1:0] pattern_source_ctrl;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sawtooth_cfg_ch1_ch2 <= SAW_CFG_RST;
      sawtooth_cfg_ch3_ch4 <= SAW_CFG_RST;
      tuning_word_high     <= REG_RST;
      tuning_word_low      <= REG_RST;
      for (int i = 0; i < NCH; i++) begin
        phase_offset[i] <= REG_RST;
      end
      pattern_trigger_ctrl <= REG_RST;
      pattern_source_ctrl  <= REG_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_SAW_CH1_CH2: sawtooth_cfg_ch1_ch2 <= reg_wdata_i;
        ADDR_SAW_CH3_CH4: sawtooth_cfg_ch3_ch4 <= reg_wdata_i;
        ADDR_TW_HIGH:     tuning_word_high     <= reg_wdata_i;
        ADDR_TW_LOW:      tuning_word_low      <= reg_wdata_i;
        ADDR_PH_CH1:      phase_offset[0]      <= reg_wdata_i;
        ADDR_PH_CH2:      phase_offset[1]      <= reg_wdata_i;
        ADDR_PH_CH3:      phase_offset[2]      <= reg_wdata_i;
        ADDR_PH_CH4:      phase_offset[3]      <= reg_wdata_i;
        ADDR_TRIG_CTRL:   pattern_trigger_ctrl <= reg_wdata_i;
        ADDR_SRC_CTRL:    pattern_source_ctrl  <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // read data registered; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      case (reg_addr_i)
        ADDR_SAW_CH1_CH2: reg_rdata_o <= sawtooth_cfg_ch1_ch2;
        ADDR_SAW_CH3_CH4: reg_rdata_o <= sawtooth_cfg_ch3_ch4;
        ADDR_TW_HIGH:     reg_rdata_o <= tuning_word_high;
        ADDR_TW_LOW:      reg_rdata_o <= tuning_word_low;
        ADDR_PH_CH1:      reg_rdata_o <= phase_offset[0];
        ADDR_PH_CH2:      reg_rdata_o <= phase_offset[1];
        ADDR_PH_CH3:      reg_rdata_o <= phase_offset[2];
        ADDR_PH_CH4:      reg_rdata_o <= phase_offset[3];
        ADDR_TRIG_CTRL:   reg_rdata_o <= pattern_trigger_ctrl;
        ADDR_SRC_CTRL:    reg_rdata_o <= pattern_source_ctrl;
        default:          reg_rdata_o <= '0;
      endcase
    end
  end

  // ==========================================================
  // field decoding
  function automatic logic [HOLD_W-1:0] hold_of(input int ch,
                                                input logic [DATA_W-1:0] c12,
                                                input logic [DATA_W-1:0] c34);
    logic [DATA_W-1:0] c;
    c = (ch < 2) ? c12 : c34;
    hold_of = (ch % 2 == 1) ? c[HOLD_ODD_LSB +: HOLD_W] : c[HOLD_EVEN_LSB +: HOLD_W];
  endfunction

  function automatic dspc_shape_t shape_of(input int ch,
                                           input logic [DATA_W-1:0] c12,
                                           input logic [DATA_W-1:0] c34);
    logic [DATA_W-1:0] c;
    c = (ch < 2) ? c12 : c34;
    shape_of = dspc_shape_t'((ch % 2 == 1) ? c[SHAPE_ODD_LSB +: 2] : c[SHAPE_EVEN_LSB +: 2]);
  endfunction

  // upper bits kept from the registers, RAM word shifted down
  function automatic logic [TW_W-1:0] place_word(input logic [TW_W-1:0] regw,
                                                 input logic [SAMP_W-1:0] ram,
                                                 input logic [SHIFT_W-1:0] sh);
    place_word = (regw & ~(TW_ONES >> sh)) | ({ram, 12'h000} >> sh);
  endfunction

  logic [TW_W-1:0] reg_freq_word;
  logic            gen_go;

  assign reg_freq_word = {tuning_word_high, tuning_word_low[TW_LOW_LSB +: 8]};
  assign first_pattern_only_delay_o = pattern_trigger_ctrl[FIRST_ONLY_BIT];

  // ==========================================================
  // RAM-sourced words: alternate between the two begin addresses
  dspc_fetch_t               fetch_state;
  dspc_fetch_t               addr_tag;
  dspc_fetch_t               data_tag;
  logic [SAMP_W-1:0]         ram_freq_word;
  logic [RAM_PH_BITS-1:0]    ram_phase_ch3;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fetch_state <= DSPC_FETCH_TW;
      addr_tag    <= DSPC_FETCH_TW;
      data_tag    <= DSPC_FETCH_TW;
      ram_addr_o  <= '0;
    end else begin
      unique case (fetch_state)
        DSPC_FETCH_TW: begin
          ram_addr_o  <= pattern_begin_ch1_i;
          fetch_state <= DSPC_FETCH_PH;
        end
        DSPC_FETCH_PH: begin
          ram_addr_o  <= pattern_begin_ch3_i;
          fetch_state <= DSPC_FETCH_TW;
        end
        default: fetch_state <= DSPC_FETCH_TW;
      endcase
      addr_tag <= fetch_state;
      data_tag <= addr_tag;
    end
  end

  // data on ram_data_i belongs to the address issued two edges back
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ram_freq_word <= '0;
      ram_phase_ch3 <= '0;
    end else if (data_tag == DSPC_FETCH_TW) begin
      ram_freq_word <= ram_data_i;
    end else begin
      ram_phase_ch3 <= ram_data_i[SAMP_W-1 -: RAM_PH_BITS];
    end
  end

  // registered so the placement shifter stays off the adder path
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      freq_word_o <= '0;
    end else if (pattern_source_ctrl[TW_RAM_BIT]) begin
      freq_word_o <= place_word(reg_freq_word, ram_freq_word, ram_freq_word_placement_i);
    end else begin
      freq_word_o <= reg_freq_word;
    end
  end

  // ==========================================================
  // phase accumulator, stalls with the output buffer
  logic [TW_W-1:0] accum;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      accum <= '0;
    end else if (gen_go) begin
      accum <= accum + freq_word_o;
    end
  end

  // ==========================================================
  // per-channel phase and sawtooth
  logic [PHASE_W-1:0] ch_phase   [NCH];
  logic [SAMP_W-1:0]  saw_level  [NCH];
  logic [NCH-1:0]     prev_msb;
  logic [NCH*SAMP_W-1:0]  next_samples;
  logic [NCH*PHASE_W-1:0] next_phases;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [PHASE_W-1:0] offset;
      logic [HOLD_W-1:0]  hold_cnt;
      logic               going_down;
      logic [HOLD_W-1:0]  hold;
      dspc_shape_t        shape;
      logic               cos_sel;
      logic               msb_step;

      assign hold     = hold_of(g, sawtooth_cfg_ch1_ch2, sawtooth_cfg_ch3_ch4);
      assign shape    = shape_of(g, sawtooth_cfg_ch1_ch2, sawtooth_cfg_ch3_ch4);
      assign cos_sel  = pattern_source_ctrl[COS_BIT_BASE + g*CH_BIT_STRIDE];
      assign msb_step = pattern_source_ctrl[MSB_BIT_BASE + g*CH_BIT_STRIDE];

      if (g == 2) begin : g_ram_ph
        // only the top RAM bits carry phase; low byte zero
        assign offset = pattern_source_ctrl[PH_RAM_BIT] ?
                        {ram_phase_ch3, 8'h00} : phase_offset[g];
      end else begin : g_reg_ph
        assign offset = phase_offset[g];
      end

      // cosine is sine advanced by a quarter turn
      assign ch_phase[g] = accum[TW_W-1 -: PHASE_W] + offset
                           + (cos_sel ? COSINE_SHIFT : 16'h0000);

      assign next_samples[g*SAMP_W +: SAMP_W]   = saw_level[g];
      assign next_phases[g*PHASE_W +: PHASE_W]  = ch_phase[g];

      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          prev_msb[g]    <= 1'b0;
          addr_step_o[g] <= 1'b0;
        end else if (gen_go) begin
          prev_msb[g]    <= ch_phase[g][PHASE_W-1];
          addr_step_o[g] <= msb_step ?
                            (ch_phase[g][PHASE_W-1] && !prev_msb[g]) : 1'b1;
        end else begin
          addr_step_o[g] <= 1'b0;
        end
      end

      // hold count of zero behaves as one
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          saw_level[g] <= '0;
          hold_cnt     <= '0;
          going_down   <= 1'b0;
        end else if (gen_go) begin
          if (HOLD_W'(hold_cnt + 6'h01) >= hold) begin
            hold_cnt <= '0;
            unique case (shape)
              DSPC_RAMP_UP:   saw_level[g] <= saw_level[g] + 12'h001;
              DSPC_RAMP_DOWN: saw_level[g] <= saw_level[g] - 12'h001;
              DSPC_TRIANGLE: begin
                if (!going_down) begin
                  if (saw_level[g] == SAW_MAX) begin
                    going_down   <= 1'b1;
                    saw_level[g] <= saw_level[g] - 12'h001;
                  end else begin
                    saw_level[g] <= saw_level[g] + 12'h001;
                  end
                end else if (saw_level[g] == 12'h000) begin
                  going_down   <= 1'b0;
                  saw_level[g] <= saw_level[g] + 12'h001;
                end else begin
                  saw_level[g] <= saw_level[g] - 12'h001;
                end
              end
              DSPC_ZERO: begin
                saw_level[g] <= '0;
                going_down   <= 1'b0;
              end
            endcase
          end else begin
            hold_cnt <= HOLD_W'(hold_cnt + 6'h01);
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // output buffer; a stalled receiver freezes the generators
  dspc_buf #(
    .W(NCH*(SAMP_W+PHASE_W))
  ) u_buf (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (1'b1),
    .in_ready_o  (gen_go),
    .in_data_i   ({next_samples, next_phases}),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  ({ch_sample_o, ch_phase_o})
  );

endmodule

/* File: verification/dspc_far_model.sv */
// dspc_far_model: pattern RAM and sample receiver facing dspc_top.
// assumes one clock; RAM answers one cycle after the address.
`timescale 1ns/1ps

module dspc_far_model
  import dspc_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        slow_i,
  input  wire logic [dspc_pkg::SAMP_W-1:0] ram_addr_i,
  output logic      [dspc_pkg::SAMP_W-1:0] ram_data_o,
  output logic                             out_ready_o
);
  import dspc_pkg::*;
  logic [1:0] tick;

  // ==========================================================
  // ram: contents are a fixed scramble of the address
  always_ff @(posedge clk_i) begin
    ram_data_o <= ram_addr_i ^ 12'h5a5;
  end

  // ==========================================================
  // receiver: slow mode takes one word in four
  always_ff @(posedge clk_i) begin
    tick <= sys_rst_i ? 2'h0 : tick + 2'h1;
    out_ready_o <= !slow_i || (tick == 2'h3);
  end
endmodule

/* File: verification/dspc_top_checker.sv */
// dspc_top_checker: port-level assertions for dspc_top.
// assumes it is bound to every dspc_top instance.
`timescale 1ns/1ps

module dspc_top_checker
  import dspc_pkg::*;
(
  input  wire logic                                clk_i,
  input  wire logic                                sys_rst_i,
  input  wire logic                                reg_wr_i,
  input  wire logic [dspc_pkg::ADDR_W-1:0]         reg_addr_i,
  input  wire logic [dspc_pkg::DATA_W-1:0]         reg_wdata_i,
  input  wire logic [dspc_pkg::DATA_W-1:0]         reg_rdata_o,
  input  wire logic [dspc_pkg::SAMP_W-1:0]         pattern_begin_ch1_i,
  input  wire logic [dspc_pkg::SAMP_W-1:0]         pattern_begin_ch3_i,
  input  wire logic [dspc_pkg::SAMP_W-1:0]         ram_addr_o,
  input  wire logic                                first_pattern_only_delay_o,
  input  wire logic [dspc_pkg::TW_W-1:0]           freq_word_o,
  input  wire logic                                out_valid_o,
  input  wire logic                                out_ready_i,
  input  wire logic [dspc_pkg::NCH*dspc_pkg::SAMP_W-1:0]  ch_sample_o,
  input  wire logic [dspc_pkg::NCH*dspc_pkg::PHASE_W-1:0] ch_phase_o
);
  import dspc_pkg::*;
  logic [DATA_W-1:0] hi, lo, src, ph1, ph2, saw12;
  logic [3:0]        quiet;
  wire               mapped = reg_addr_i inside {ADDR_SAW_CH3_CH4, ADDR_SAW_CH1_CH2, [ADDR_TW_HIGH:ADDR_SRC_CTRL]};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ==========================================================
  // shadow registers; quiet counts words taken since last write
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      {hi, lo, src, ph1, ph2} <= '0;
      saw12 <= SAW_CFG_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_TW_HIGH:     hi <= reg_wdata_i;
        ADDR_TW_LOW:      lo <= reg_wdata_i;
        ADDR_SRC_CTRL:    src <= reg_wdata_i;
        ADDR_PH_CH1:      ph1 <= reg_wdata_i;
        ADDR_PH_CH2:      ph2 <= reg_wdata_i;
        ADDR_SAW_CH1_CH2: saw12 <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || reg_wr_i) quiet <= 4'h0;
    else if (out_valid_o && out_ready_i && quiet != 4'hf) quiet <= quiet + 4'h1;
  end

  // ==========================================================
  // assertions
  unmapped_read_a: assert property (!mapped |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
  write_readback_a: assert property (reg_wr_i && mapped ##1 !reg_wr_i && $stable(reg_addr_i)
    |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("read back differs from write");
  stall_hold_a: assert property (out_valid_o && !out_ready_i
    |=> out_valid_o && $stable(ch_sample_o) && $stable(ch_phase_o)) else $error("word changed while stalled");
  delay_bit_a: assert property (reg_wr_i && reg_addr_i == ADDR_TRIG_CTRL ##1 !reg_wr_i
    |=> first_pattern_only_delay_o == $past(reg_wdata_i[1], 2)) else $error("delay mode bit wrong");
  reg_freq_word_a: assert property (!$past(src[0]) |-> freq_word_o == $past({hi, lo[15:8]})) else $error("tuning word wrong");
  phase_spacing_a: assert property (quiet > 4'h7 && out_valid_o |-> ch_phase_o[31:16] - ch_phase_o[15:0]
    == 16'(ph2 - ph1 + (src[7] ? 16'h4000 : 16'h0) - (src[3] ? 16'h4000 : 16'h0))) else $error("phase offset wrong");
  ram_alternate_a: assert property (pattern_begin_ch1_i != pattern_begin_ch3_i && $stable(pattern_begin_ch1_i)
    && $stable(pattern_begin_ch3_i) |=> ram_addr_o != $past(ram_addr_o)) else $error("ram address not alternating");
  zero_shape_a: assert property (quiet > 4'h7 && out_valid_o && saw12[9:8] == 2'h3
    |-> ch_sample_o[23:12] == 12'h000) else $error("zero shape not zero");
  reset_clear_a: assert property ($fell(sys_rst_i) |-> freq_word_o == 24'h0 && !first_pattern_only_delay_o)
    else $error("outputs not cleared by reset");

  stall_c: cover property (out_valid_o && !out_ready_i);
  ram_word_c: cover property (src[0] && quiet == 4'hf);
  ram_phase_c: cover property (src[9] && out_valid_o && out_ready_i);
endmodule

bind dspc_top dspc_top_checker chk_u (.clk_i, .sys_rst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .pattern_begin_ch1_i, .pattern_begin_ch3_i, .ram_addr_o, .first_pattern_only_delay_o, .freq_word_o,
  .out_valid_o, .out_ready_i, .ch_sample_o, .ch_phase_o);

/* File: verification/dspc_top_bench.sv */
// dspc_top_bench: register, tuning word, phase and sawtooth tests.
// assumes dspc_far_model plays the RAM and the receiver.
`timescale 1ns/1ps

module dspc_top_bench;
  import dspc_pkg::*;
  logic                   clk_i = 1'b0;
  logic                   sys_rst_i = 1'b1;
  logic                   reg_wr_i = 1'b0;
  logic                   slow = 1'b0;
  logic [ADDR_W-1:0]      reg_addr_i = 7'h00;
  logic [DATA_W-1:0]      reg_wdata_i = 16'h0000, reg_rdata_o;
  logic [SAMP_W-1:0]      pattern_begin_ch1_i = 12'h123, pattern_begin_ch3_i = 12'h456, ram_addr_o, ram_data_i;
  logic [SHIFT_W-1:0]     ram_freq_word_placement_i = 5'h00;
  logic                   first_pattern_only_delay_o, out_valid_o, out_ready_i;
  logic [NCH-1:0]         addr_step_o;
  logic [TW_W-1:0]        freq_word_o;
  logic [NCH*SAMP_W-1:0]  ch_sample_o, s0;
  logic [NCH*PHASE_W-1:0] ch_phase_o, p0, p1;
  logic [ADDR_W-1:0]      addrs [11] = '{ADDR_SAW_CH3_CH4, ADDR_SAW_CH1_CH2, ADDR_TW_HIGH, ADDR_TW_LOW, ADDR_PH_CH4,
                                         ADDR_PH_CH3, ADDR_PH_CH2, ADDR_PH_CH1, ADDR_TRIG_CTRL, ADDR_SRC_CTRL, 7'h38};
  logic [SHIFT_W-1:0]     sh [5] = '{5'h00, 5'h01, 5'h0c, 5'h10, 5'h00};
  logic [SAMP_W-1:0]      lv [13], rw;
  logic [SAMP_W-1:0]      stp [3] = '{12'h001, 12'hfff, 12'h000};
  logic [1:0]             shp [3] = '{2'h0, 2'h1, 2'h3};
  int                     fails = 0, n_tests = 0, cnt, j;

  always #5 clk_i = ~clk_i;

  dspc_top dut (.clk_i, .sys_rst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .pattern_begin_ch1_i,
    .pattern_begin_ch3_i, .ram_freq_word_placement_i, .ram_addr_o, .ram_data_i, .first_pattern_only_delay_o,
    .addr_step_o, .freq_word_o, .out_valid_o, .out_ready_i, .ch_sample_o, .ch_phase_o);
  dspc_far_model far (.clk_i, .sys_rst_i, .slow_i(slow), .ram_addr_i(ram_addr_o), .ram_data_o(ram_data_i),
    .out_ready_o(out_ready_i));

  // ==========================================================
  // tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(negedge clk_i);
    reg_addr_i = a;
    @(negedge clk_i);
    chk(reg_rdata_o, exp);
  endtask

  // word is taken at the next rising edge, so each negedge sees a new one
  task automatic get(output logic [NCH*SAMP_W-1:0] s, output logic [NCH*PHASE_W-1:0] p);
    for (int i = 0; i < 100; i++) begin
      @(negedge clk_i);
      if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
        s = ch_sample_o;
        p = ch_phase_o;
        return;
      end
    end
    chk(64'h0, 64'h1);
  endtask

  task automatic summarize();
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 11; i++) rd(addrs[i], (i < 2) ? 16'h0404 : 16'h0000);
    chk(freq_word_o, 24'h000000);
    for (int i = 0; i < 11; i++) wr(addrs[i], 16'ha5c3 ^ 16'(i));
    for (int i = 0; i < 11; i++) rd(addrs[i], (i < 10) ? 16'ha5c3 ^ 16'(i) : 16'h0000);
    chk(first_pattern_only_delay_o, 1'b1);
    wr(ADDR_TRIG_CTRL, 16'h0000);
    repeat (2) @(negedge clk_i);
    chk(first_pattern_only_delay_o, 1'b0);
    wr(ADDR_SRC_CTRL, 16'h8080);
    wr(ADDR_TW_HIGH, 16'h1234);
    wr(ADDR_TW_LOW, 16'h56ab);
    repeat (2) @(negedge clk_i);
    chk(freq_word_o, 24'h123456);
    wr(ADDR_TW_HIGH, 16'h0100);
    wr(ADDR_TW_LOW, 16'h0000);
    wr(ADDR_PH_CH1, 16'h1111);
    wr(ADDR_PH_CH2, 16'h2222);
    wr(ADDR_PH_CH3, 16'h3000);
    wr(ADDR_PH_CH4, 16'h0040);
    for (int i = 0; i < 2; i++) begin
      repeat (10) get(s0, p0);
      get(s0, p1);
      chk(16'(p1[15:0] - p0[15:0]), 16'h0100);
      chk(16'(p1[31:16] - p1[15:0]), 16'h5111);
      chk(16'(p1[47:32] - p1[15:0]), (i == 1) ? 16'h0def : 16'h1eef);
      chk(16'(p1[63:48] - p1[15:0]), 16'h2f2f);
      wr(ADDR_SRC_CTRL, 16'h8280);
    end
    wr(ADDR_SRC_CTRL, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      ram_freq_word_placement_i = sh[i];
      pattern_begin_ch1_i = (i == 4) ? 12'h200 : 12'h123;
      rw = (i == 4) ? 12'h7a5 : 12'h486;
      repeat (8) @(negedge clk_i);
      chk(freq_word_o, (24'h010000 & ~(24'hffffff >> sh[i])) | ({rw, 12'h000} >> sh[i]));
    end
    wr(ADDR_SRC_CTRL, 16'h0000);
    repeat (4) @(negedge clk_i);
    chk(addr_step_o, 4'hf);
    wr(ADDR_TW_HIGH, 16'h1000);
    wr(ADDR_SRC_CTRL, 16'h0004);
    repeat (8) @(negedge clk_i);
    cnt = 0;
    j = 0;
    repeat (64) begin
      @(negedge clk_i);
      cnt += addr_step_o[0];
      j += addr_step_o[1];
    end
    chk(cnt, 4);
    chk(j, 64);
    // slow receiver on the falling ramp: stalls must not drop levels
    for (int k = 0; k < 3; k++) begin
      slow = (k == 1);
      wr(ADDR_SAW_CH1_CH2, 16'h070c | 16'(shp[k]));
      repeat (10) get(s0, p0);
      for (int i = 0; i < 13; i++) begin
        get(s0, p0);
        lv[i] = s0[11:0];
        chk(s0[23:12], 12'h000);
      end
      j = 1;
      while (j < 3 && lv[j] === lv[j-1]) j++;
      for (int i = 1; i < 13; i++) chk(12'(lv[i] - lv[i-1]), ((i - j) % 3 == 0) ? stp[k] : 12'h000);
      chk((k == 2) ? lv[0] : 12'h000, 12'h000);
    end
    summarize();
  end

  initial begin
    #300us;
    fails++;
    summarize();
  end
endmodule
